// ### src/code_bank_if.sv
// code address carried to the bank mapper
`timescale 1ns/10ps
interface code_bank_if;
  logic [15:0] addr;
  logic [1:0]  bank;
  logic        three_bank;
  logic [16:0] flat;
  logic        reserved;
  modport master (output addr, output bank, output three_bank, input flat, input reserved);
  modport mapper (input addr, input bank, input three_bank, output flat, output reserved);
endinterface

// ### src/code_bank_map.sv
// maps one 16-bit code address to a 17-bit flash address
`timescale 1ns/10ps
`include "mem_map_regs.svh"
module code_bank_map
  import mem_map_pkg::*;
(
  code_bank_if.mapper cb
);
  logic upper;
  assign upper = cb.addr[`UPPER_CODE_BIT];
  // lower half always bank 0
  assign cb.flat = upper ? {cb.bank, cb.addr[14:0]} : {2'b00, cb.addr[14:0]};
  // top of bank 3 reserved on four bank part
  assign cb.reserved = upper && (cb.bank == 2'b11) && !cb.three_bank
                       && (cb.addr >= `RESERVED_CODE_BASE);
endmodule // code_bank_map

// ### src/mem_map_pkg.sv
// types for the memory map and bank decoder
package mem_map_pkg;
  typedef logic [1:0] bank_t;
  typedef enum logic [1:0] {
    DST_IRAM = 2'b00,
    DST_SFR  = 2'b01,
    DST_NONE = 2'b10
  } data_dst_t;
  typedef enum logic [1:0] {
    STK_IDLE = 2'b00,
    STK_PUSH = 2'b01,
    STK_POP  = 2'b10
  } stack_op_t;
endpackage

// ### src/mem_map_regs.svh
// constants for the memory map and bank decoder
`ifndef MEM_MAP_REGS_SVH
`define MEM_MAP_REGS_SVH
`define PROG_BANK_SEL_ADDR   8'hf5
`define PROG_BANK_SEL_RESET  8'h11
`define FETCH_BANK_LSB       0
`define CONST_BANK_LSB       4
`define PROG_BANK_SEL_MASK   8'h33
`define STACK_PTR_ADDR       8'h81
`define PSW_ADDR             8'hd0
`define PSW_BANK_LSB         3
`define STACK_PTR_RESET      8'h07
`define UPPER_CODE_BIT       15
`define RESERVED_CODE_BASE   16'hfc00
`define LOWER_RAM_TOP        8'h7f
`define BIT_AREA_BASE        8'h20
`define EXT_RAM_AW           13
`endif

// ### src/memory_map_bank_decoder.sv
// memory map, bank select register, register banks and stack pointer
`timescale 1ns/10ps
`include "mem_map_regs.svh"
module memory_map_bank_decoder
  import mem_map_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic        three_bank_i,
  input  wire logic [15:0] fetch_addr_i,
  input  wire logic        fetch_req_i,
  input  wire logic [15:0] const_addr_i,
  input  wire logic        const_req_i,
  input  wire logic        const_write_i,
  input  wire logic        flash_wr_en_i,
  input  wire logic        ext_req_i,
  input  wire logic        ext_write_i,
  input  wire logic [15:0] ext_addr_i,
  input  wire logic [15:0] exec_pc_i,
  input  wire logic        sfr_wr_i,
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  input  wire logic        data_req_i,
  input  wire logic        data_indirect_i,
  input  wire logic        data_bit_i,
  input  wire logic        data_use_reg_i,
  input  wire logic [2:0]  data_reg_i,
  input  wire logic [7:0]  data_addr_i,
  input  wire logic        ptr_sel_i,
  input  wire logic [7:0]  ptr_value_i,
  input  wire logic        push_i,
  input  wire logic        pop_i,
  output logic      [16:0] fetch_flash_addr_o,
  output logic             fetch_reserved_o,
  output logic      [16:0] const_flash_addr_o,
  output logic             const_reserved_o,
  output logic             const_flash_wr_o,
  output logic             ext_ram_sel_o,
  output logic [12:0]      ext_ram_addr_o,
  output logic             ext_flash_wr_o,
  output logic [7:0]       iram_addr_o,
  output logic             iram_sel_o,
  output logic             sfr_sel_o,
  output logic             bit_access_o,
  output logic [2:0]       bit_pos_o,
  output logic [7:0]       ptr_reg_addr_o,
  output logic [7:0]       stack_addr_o,
  output logic [7:0]       stack_pointer_o,
  output logic [7:0]       program_bank_select_o,
  output logic [1:0]       reg_bank_o
);
  logic [1:0]  fetch_bank_ff;
  logic [1:0]  const_bank_ff;
  logic [7:0]  stack_pointer_ff;
  logic        reg_bank_sel_lo_ff;
  logic        reg_bank_sel_hi_ff;
  logic [16:0] fetch_flash_addr_ff;
  logic        fetch_reserved_ff;
  logic [16:0] const_flash_addr_ff;
  logic        const_reserved_ff;
  logic        const_flash_wr_ff;
  logic        ext_ram_sel_ff;
  logic [12:0] ext_ram_addr_ff;
  logic        ext_flash_wr_ff;
  logic [7:0]  iram_addr_ff;
  logic        iram_sel_ff;
  logic        sfr_sel_ff;
  logic        bit_access_ff;
  logic [2:0]  bit_pos_ff;
  logic [7:0]  ptr_reg_addr_ff;
  logic [7:0]  stack_addr_ff;
  logic        three_bank_meta_ff;
  logic        three_bank_ff;
  logic [1:0]  reg_bank;
  logic        bank_wr;
  logic [7:0]  nxt_iram_addr;
  logic        nxt_iram_sel;
  logic        nxt_sfr_sel;
  logic [2:0]  nxt_bit_pos;
  logic [7:0]  nxt_program_bank_select;
  logic [7:0]  program_bank_select_ff;
  logic [1:0]  reg_bank_ff;
  logic        psw_wr;
  logic        sp_wr;
  code_bank_if fetch_cb ();
  code_bank_if const_cb ();

  // strap comes from a pin
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      three_bank_meta_ff <= 1'b0;
      three_bank_ff      <= 1'b0;
    end else begin
      three_bank_meta_ff <= three_bank_i;
      three_bank_ff      <= three_bank_meta_ff;
    end
  end

  // bank select register
  assign bank_wr = sfr_wr_i && (sfr_addr_i == `PROG_BANK_SEL_ADDR);
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fetch_bank_ff <= bank_t'(`PROG_BANK_SEL_RESET >> `FETCH_BANK_LSB);
      const_bank_ff <= bank_t'(`PROG_BANK_SEL_RESET >> `CONST_BANK_LSB);
    end else if (bank_wr) begin
      const_bank_ff <= sfr_wdata_i[`CONST_BANK_LSB +: 2];
      if (!exec_pc_i[`UPPER_CODE_BIT]) begin
        fetch_bank_ff <= sfr_wdata_i[`FETCH_BANK_LSB +: 2];
      end
    end
  end

  // status word bank bits
  assign psw_wr = sfr_wr_i && (sfr_addr_i == `PSW_ADDR);
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_bank_sel_lo_ff <= 1'b0;
      reg_bank_sel_hi_ff <= 1'b0;
    end else if (psw_wr) begin
      reg_bank_sel_lo_ff <= sfr_wdata_i[`PSW_BANK_LSB];
      reg_bank_sel_hi_ff <= sfr_wdata_i[`PSW_BANK_LSB + 1];
    end
  end
  assign reg_bank = {reg_bank_sel_hi_ff, reg_bank_sel_lo_ff};

  // code side mapping
  assign fetch_cb.addr       = fetch_addr_i;
  assign fetch_cb.bank       = fetch_bank_ff;
  assign fetch_cb.three_bank = three_bank_ff;
  assign const_cb.addr       = const_addr_i;
  assign const_cb.bank       = const_bank_ff;
  assign const_cb.three_bank = three_bank_ff;
  code_bank_map u_fetch_map (
    .cb (fetch_cb.mapper)
  );
  code_bank_map u_const_map (
    .cb (const_cb.mapper)
  );

  // fetch address capture
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fetch_flash_addr_ff <= 17'h0_0000;
      fetch_reserved_ff   <= 1'b0;
    end else if (fetch_req_i) begin
      fetch_flash_addr_ff <= fetch_cb.flat;
      fetch_reserved_ff   <= fetch_cb.reserved;
    end
  end

  // constant reads and flash writes
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      const_flash_addr_ff <= 17'h0_0000;
      const_reserved_ff   <= 1'b0;
    end else if (const_req_i) begin
      const_flash_addr_ff <= const_cb.flat;
      const_reserved_ff   <= const_cb.reserved;
    end
  end

  // flash write pulse, never into the reserved area
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      const_flash_wr_ff <= 1'b0;
    end else begin
      const_flash_wr_ff <= const_req_i && const_write_i && !const_cb.reserved;
    end
  end

  // external data moves
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_ram_sel_ff  <= 1'b0;
      ext_flash_wr_ff <= 1'b0;
    end else begin
      ext_flash_wr_ff <= ext_req_i && ext_write_i && flash_wr_en_i;
      ext_ram_sel_ff  <= ext_req_i && !(ext_write_i && flash_wr_en_i);
    end
  end

  // extended ram address, held between moves
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_ram_addr_ff <= 13'h0000;
    end else if (ext_req_i) begin
      ext_ram_addr_ff <= ext_addr_i[`EXT_RAM_AW-1:0];
    end
  end

  // data address decode
  always_comb begin
    nxt_iram_addr = data_addr_i;
    nxt_iram_sel  = 1'b0;
    nxt_sfr_sel   = 1'b0;
    nxt_bit_pos   = 3'h0;
    if (!data_req_i) begin
      nxt_iram_sel = 1'b0;
    end else if (data_use_reg_i) begin
      nxt_iram_addr = {3'b000, reg_bank, data_reg_i};
      nxt_iram_sel  = 1'b1;
    end else if (data_bit_i) begin
      if (data_addr_i <= `LOWER_RAM_TOP) begin
        nxt_iram_addr = `BIT_AREA_BASE + {4'h0, data_addr_i[6:3]};
        nxt_iram_sel  = 1'b1;
      end else begin
        nxt_iram_addr = {data_addr_i[7:3], 3'b000};
        nxt_sfr_sel   = 1'b1;
      end
      nxt_bit_pos = data_addr_i[2:0];
    end else if (data_indirect_i) begin
      nxt_iram_addr = ptr_value_i;
      nxt_iram_sel  = 1'b1;
    end else if (data_addr_i <= `LOWER_RAM_TOP) begin
      nxt_iram_sel = 1'b1;
    end else begin
      nxt_sfr_sel = 1'b1;
    end
  end

  // data routing flags
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      iram_addr_ff <= 8'h00;
      iram_sel_ff  <= 1'b0;
      sfr_sel_ff   <= 1'b0;
    end else begin
      iram_addr_ff <= nxt_iram_addr;
      iram_sel_ff  <= nxt_iram_sel;
      sfr_sel_ff   <= nxt_sfr_sel;
    end
  end

  // bit or byte access flag
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bit_access_ff <= 1'b0;
      bit_pos_ff    <= 3'h0;
    end else begin
      bit_access_ff <= data_req_i && data_bit_i;
      bit_pos_ff    <= nxt_bit_pos;
    end
  end

  // pointer register of the active bank
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ptr_reg_addr_ff <= 8'h00;
    end else begin
      ptr_reg_addr_ff <= {3'b000, reg_bank, 2'b00, ptr_sel_i};
    end
  end

  // stack pointer, wraps over all 256 bytes
  assign sp_wr = sfr_wr_i && (sfr_addr_i == `STACK_PTR_ADDR);
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stack_pointer_ff <= `STACK_PTR_RESET;
    end else if (push_i) begin
      stack_pointer_ff <= stack_pointer_ff + 8'h01;
    end else if (pop_i) begin
      stack_pointer_ff <= stack_pointer_ff - 8'h01;
    end else if (sp_wr) begin
      stack_pointer_ff <= sfr_wdata_i;
    end
  end

  // address of the current push or pop
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stack_addr_ff <= 8'h00;
    end else if (push_i) begin
      stack_addr_ff <= stack_pointer_ff + 8'h01;
    end else if (pop_i) begin
      stack_addr_ff <= stack_pointer_ff;
    end
  end

  // status outputs, reserved bits zero
  always_comb begin
    nxt_program_bank_select                       = 8'h00;
    nxt_program_bank_select[`CONST_BANK_LSB +: 2] = const_bank_ff;
    nxt_program_bank_select[`FETCH_BANK_LSB +: 2] = fetch_bank_ff;
    nxt_program_bank_select = nxt_program_bank_select & `PROG_BANK_SEL_MASK;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      program_bank_select_ff <= `PROG_BANK_SEL_RESET;
    end else begin
      program_bank_select_ff <= nxt_program_bank_select;
    end
  end

  // active register bank seen by the core
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_bank_ff <= 2'b00;
    end else begin
      reg_bank_ff <= reg_bank;
    end
  end

  assign fetch_flash_addr_o = fetch_flash_addr_ff;
  assign fetch_reserved_o   = fetch_reserved_ff;
  assign const_flash_addr_o = const_flash_addr_ff;
  assign const_reserved_o   = const_reserved_ff;
  assign const_flash_wr_o   = const_flash_wr_ff;
  assign ext_ram_sel_o      = ext_ram_sel_ff;
  assign ext_ram_addr_o     = ext_ram_addr_ff;
  assign ext_flash_wr_o     = ext_flash_wr_ff;
  assign iram_addr_o        = iram_addr_ff;
  assign iram_sel_o         = iram_sel_ff;
  assign sfr_sel_o          = sfr_sel_ff;
  assign bit_access_o       = bit_access_ff;
  assign bit_pos_o          = bit_pos_ff;
  assign ptr_reg_addr_o     = ptr_reg_addr_ff;
  assign stack_addr_o       = stack_addr_ff;
  assign stack_pointer_o    = stack_pointer_ff;
  assign program_bank_select_o = program_bank_select_ff;
  assign reg_bank_o         = reg_bank_ff;
endmodule // memory_map_bank_decoder

// ### test/core_regs_model.sv
// core register file model answering pointer reads
`timescale 1ns/10ps
module core_regs_model (
  input  wire logic [7:0] ptr_reg_addr_i,
  output logic      [7:0] ptr_value_o
);
  // pointers aim at upper ram
  assign ptr_value_o = 8'h80 | ptr_reg_addr_i;
endmodule // core_regs_model

// ### test/mmbd_checker.sv
// port checker for the memory map bank decoder
`timescale 1ns/10ps
module mmbd_checker (
  input wire logic        mclk_i,
  input wire logic        rstn_i,
  input wire logic        fetch_req_i,
  input wire logic        const_req_i,
  input wire logic        sfr_wr_i,
  input wire logic        push_i,
  input wire logic        pop_i,
  input wire logic        data_req_i,
  input wire logic        data_indirect_i,
  input wire logic        iram_sel_o,
  input wire logic        sfr_sel_o,
  input wire logic [15:0] fetch_addr_i,
  input wire logic [15:0] const_addr_i,
  input wire logic [15:0] exec_pc_i,
  input wire logic [16:0] fetch_flash_addr_o,
  input wire logic [16:0] const_flash_addr_o,
  input wire logic [7:0]  sfr_addr_i,
  input wire logic [7:0]  program_bank_select_o,
  input wire logic [7:0]  stack_pointer_o,
  input wire logic [7:0]  stack_addr_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  property p_lo; fetch_req_i && !fetch_addr_i[15] |=> fetch_flash_addr_o[16:15] == 2'b00; endproperty
  a_lo: assert property (p_lo) else $error("lower half left bank 0");
  property p_hi; fetch_req_i && fetch_addr_i[15] |=>
    fetch_flash_addr_o[16:15] == program_bank_select_o[1:0]; endproperty
  a_hi: assert property (p_hi) else $error("fetch bank wrong");
  property p_co; const_req_i && const_addr_i[15] |=>
    const_flash_addr_o[16:15] == program_bank_select_o[5:4]; endproperty
  a_co: assert property (p_co) else $error("constant bank wrong");
  property p_rsv; (program_bank_select_o & 8'hcc) == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
  property p_lock; sfr_wr_i && sfr_addr_i == 8'hf5 && exec_pc_i[15] |=>
    ##1 $stable(program_bank_select_o[1:0]); endproperty
  a_lock: assert property (p_lock) else $error("fetch field changed from upper code");
  property p_ind; data_req_i && data_indirect_i |=> iram_sel_o && !sfr_sel_o; endproperty
  a_ind: assert property (p_ind) else $error("indirect not routed to ram");
  property p_push; push_i |=> stack_pointer_o == $past(stack_pointer_o) + 8'h01
    && stack_addr_o == stack_pointer_o; endproperty
  a_push: assert property (p_push) else $error("push pointer wrong");
  property p_pop; pop_i && !push_i |=> stack_pointer_o == $past(stack_pointer_o) - 8'h01
    && stack_addr_o == $past(stack_pointer_o); endproperty
  a_pop: assert property (p_pop) else $error("pop pointer wrong");
endmodule // mmbd_checker
bind memory_map_bank_decoder mmbd_checker chk (.*);

// ### test/test_memory_map_bank_decoder.sv
// self-checking bench for the memory map bank decoder
`timescale 1ns/10ps
module test_memory_map_bank_decoder;
  typedef struct {int kind; int due; logic [31:0] v;} note_t;
  logic        mclk_i = 0, rstn_i = 0, three_bank_i = 0, fetch_req_i = 0, const_req_i = 0;
  logic        const_write_i = 0, flash_wr_en_i = 0, ext_req_i = 0, ext_write_i = 0;
  logic        sfr_wr_i = 0, data_req_i = 0, data_indirect_i = 0, data_bit_i = 0;
  logic        data_use_reg_i = 0, ptr_sel_i = 0, push_i = 0, pop_i = 0;
  logic [15:0] fetch_addr_i = 0, const_addr_i = 0, ext_addr_i = 0, exec_pc_i = 0;
  logic [7:0]  sfr_addr_i = 0, sfr_wdata_i = 0, data_addr_i = 0;
  logic [2:0]  data_reg_i = 0, bit_pos_o;
  wire  [7:0]  ptr_value_i;
  logic [16:0] fetch_flash_addr_o, const_flash_addr_o;
  logic [12:0] ext_ram_addr_o;
  logic [7:0]  iram_addr_o, ptr_reg_addr_o, stack_addr_o, stack_pointer_o, program_bank_select_o;
  logic [1:0]  reg_bank_o;
  logic        fetch_reserved_o, const_reserved_o, const_flash_wr_o, ext_ram_sel_o;
  logic        ext_flash_wr_o, iram_sel_o, sfr_sel_o, bit_access_o;
  note_t       q[$];
  int          n_fail = 0, comparisons = 0, cyc = 0;
  integer      seed = 32'hf447;

  memory_map_bank_decoder dut (.*);
  core_regs_model partner (.ptr_reg_addr_i(ptr_reg_addr_o), .ptr_value_o(ptr_value_i));

  always #12.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 1000) begin
      n_fail++;
      summarize;
    end
  end

  task automatic tally(int k, logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t kind %0d got %h expected %h", $time, k, got, exp);
    end
  endtask
  task automatic cmp_code(note_t n);
    if (n.kind == 0) tally(n.kind, {14'h0, fetch_reserved_o, fetch_flash_addr_o}, n.v);
    else tally(n.kind, {14'h0, const_reserved_o, const_flash_addr_o}, n.v);
  endtask
  task automatic cmp_data(note_t n);
    tally(n.kind, {21'h0, iram_sel_o, sfr_sel_o, bit_access_o, iram_addr_o}, n.v);
  endtask
  task automatic cmp_stack(note_t n);
    tally(n.kind, {16'h0, stack_addr_o, stack_pointer_o}, n.v);
  endtask
  task automatic cmp_regs(note_t n);
    tally(n.kind, {14'h0, reg_bank_o, ptr_reg_addr_o, program_bank_select_o}, n.v);
  endtask
  task automatic cmp_route(note_t n);
    tally(n.kind, {30'h0, iram_sel_o, sfr_sel_o}, n.v);
  endtask
  task automatic cmp_bit(note_t n);
    tally(n.kind, {29'h0, bit_pos_o}, n.v);
  endtask
  task automatic cmp_ext_addr(note_t n);
    tally(n.kind, {19'h0, ext_ram_addr_o}, n.v);
  endtask
  task automatic cmp_strobes(note_t n);
    tally(n.kind, {29'h0, ext_ram_sel_o, ext_flash_wr_o, const_flash_wr_o}, n.v);
  endtask
  task automatic compare(note_t n);
    case (n.kind)
      0, 1: cmp_code(n);
      2: cmp_data(n);
      3: cmp_stack(n);
      4: cmp_regs(n);
      6: cmp_route(n);
      7: cmp_bit(n);
      8: cmp_ext_addr(n);
      default: cmp_strobes(n);
    endcase
  endtask
  always @(negedge mclk_i) while (q.size() > 0 && q[0].due <= cyc) compare(q.pop_front());

  function automatic logic [15:0] rnd();
    return 16'($random(seed));
  endfunction
  task automatic note(int k, int d, logic [31:0] v);
    q.push_back('{k, cyc + d, v});
  endtask
  // strobes: fetch, const, const write, ext, sfr write, data, push, pop
  task automatic tick(logic [7:0] s = 8'h00);
    @(posedge mclk_i);
    #1;
    {fetch_req_i, const_req_i, const_write_i, ext_req_i, sfr_wr_i, data_req_i, push_i, pop_i} = s;
  endtask
  task automatic sfr(logic [7:0] a, d, logic [15:0] pc);
    tick(8'h08);
    {sfr_addr_i, sfr_wdata_i, exec_pc_i} = {a, d, pc};
  endtask
  task automatic code(logic c, logic [15:0] a, logic [1:0] b, logic w = 1'b0);
    tick({!c, c, c && w, 5'b00000});
    if (c) const_addr_i = a;
    else fetch_addr_i = a;
    note(c, 1, {14'h0, !three_bank_i && b == 2'b11 && a >= 16'hfc00,
                a[15] ? b : 2'b00, a[14:0]});
  endtask
  task automatic data(logic ind, bt, ur, logic [2:0] r, logic [7:0] a);
    tick(8'h04);
    {data_indirect_i, data_bit_i, data_use_reg_i} = {ind, bt, ur};
    {data_reg_i, data_addr_i} = {r, a};
  endtask
  task automatic stk(logic pu, logic [7:0] sa, sp);
    tick({6'b000000, pu, !pu});
    note(3, 1, {16'h0, sa, sp});
  endtask
  task automatic ext(logic w, en);
    logic [15:0] a;
    a = rnd();
    tick(8'h10);
    {ext_write_i, flash_wr_en_i, ext_addr_i} = {w, en, a};
    note(8, 1, {19'h0, a[12:0]});
  endtask
  task automatic summarize;
    n_fail += q.size();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge mclk_i);
    #1 rstn_i = 1;
    note(3, 1, {16'h0, 8'h00, 8'h07});
    note(4, 1, {16'h0, 8'h00, 8'h11});
    sfr(8'hf5, 8'h33, 16'h0100);
    note(4, 2, {16'h0, 8'h00, 8'h33});
    for (int b = 0; b < 4; b++) begin
      sfr(8'hf5, {2'b00, b[1:0], 2'b00, b[1:0]}, 16'h7fff & rnd());
      code(0, 16'h7fff & rnd(), b[1:0]);
      code(0, 16'h8000 | rnd(), b[1:0]);
      code(0, 16'hfbff, b[1:0]);
      code(1, 16'hfc00 | rnd(), b[1:0]);
      code(1, 16'h8000 | rnd(), b[1:0]);
    end
    sfr(8'hf5, 8'h22, 16'h8000 | rnd());
    note(4, 2, {16'h0, 8'h00, 8'h23});
    for (int b = 0; b < 4; b++) begin
      sfr(8'hd0, {3'b000, b[1:0], 3'b000}, 16'h0000);
      ptr_sel_i = b[0];
      note(4, 2, {14'h0, b[1:0], 3'b000, b[1:0], 2'b00, b[0], 8'h23});
      data(0, 0, 1, 3'h5, 8'h00);
      note(2, 1, {21'h0, 3'b100, 3'b000, b[1:0], 3'b101});
      tick;
      data(1, 0, 0, 3'h0, 8'h00);
      note(2, 1, {21'h0, 3'b100, 3'b100, b[1:0], 2'b00, b[0]});
    end
    data(0, 0, 0, 3'h0, 8'h7f);
    note(2, 1, {21'h0, 3'b100, 8'h7f});
    data(0, 0, 0, 3'h0, 8'h80);
    note(6, 1, 32'h1);
    data(0, 1, 0, 3'h0, 8'h13);
    note(2, 1, {21'h0, 3'b101, 8'h22});
    note(7, 1, 32'h3);
    data(0, 1, 0, 3'h0, 8'h7f);
    note(2, 1, {21'h0, 3'b101, 8'h2f});
    note(7, 1, 32'h7);
    data(0, 1, 0, 3'h0, 8'hd3);
    note(2, 1, {21'h0, 3'b011, 8'hd0});
    note(7, 1, 32'h3);
    stk(1, 8'h08, 8'h08);
    stk(1, 8'h09, 8'h09);
    stk(0, 8'h09, 8'h08);
    stk(0, 8'h08, 8'h07);
    sfr(8'h81, 8'hff, 16'h0000);
    stk(1, 8'h00, 8'h00);
    stk(0, 8'h00, 8'hff);
    ext(0, 0);
    note(5, 1, 32'h4);
    ext(1, 1);
    note(5, 1, 32'h2);
    code(1, 16'h9000, 2'b10, 1'b1);
    note(5, 1, 32'h1);
    sfr(8'hf5, 8'h11, 16'h0000);
    three_bank_i = 1'b1;
    repeat (2) tick;
    code(0, 16'hfc00 | rnd(), 2'b01);
    code(1, 16'hffff, 2'b01);
    repeat (3) tick;
    summarize;
  end
endmodule // test_memory_map_bank_decoder
